/* hw/csc_consts.svh */
// offsets, reset values, field positions and bus constants of the clock synthesizer register bank
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

// register offsets
`define CSC_OFS_GENERAL      8'h00
`define CSC_OFS_VARIANT      8'h01
`define CSC_OFS_XTAL_TRIM    8'h02
`define CSC_OFS_L3_REF       8'h03
`define CSC_OFS_L3_FB_LOW    8'h04
`define CSC_OFS_L3_FILT_FB   8'h05
`define CSC_OFS_L3_PUMP      8'h06
`define CSC_OFS_L1_CTRL      8'h07
`define CSC_OFS_L1_REF       8'h08
`define CSC_OFS_L1_FB_LOW    8'h09
`define CSC_OFS_L1_FILT_FB   8'h0A
`define CSC_NUM_REGS         11
`define CSC_LAST_OFS         8'h0A

// power-on values
`define CSC_RST_GENERAL      8'h00
`define CSC_RST_VARIANT      8'h00
`define CSC_RST_XTAL_TRIM    8'h11
`define CSC_RST_L3_REF       8'h19
`define CSC_RST_L3_FB_LOW    8'hE0
`define CSC_RST_L3_FILT_FB   8'h11
`define CSC_RST_L3_PUMP      8'h6C
`define CSC_RST_L1_CTRL      8'h23
`define CSC_RST_L1_REF       8'h19
`define CSC_RST_L1_FB_LOW    8'h58
`define CSC_RST_L1_FILT_FB   8'hB2

// writable bits; bit 1 of the general register is reserved
`define CSC_WMASK_GENERAL    8'hFD
`define CSC_WMASK_FULL       8'hFF

// general register fields
`define CSC_GEN_OTP_DONE     7
`define CSC_GEN_ADDR_HI      6
`define CSC_GEN_ADDR_LO      5
`define CSC_GEN_SPREAD       4
`define CSC_GEN_DIV1_SRC     3
`define CSC_GEN_L3_SRC       2
`define CSC_GEN_OTP_LOCK     0

// reference divider fields (same layout for both loops)
`define CSC_REF_BYP1         7
`define CSC_REF_BYP2         6
`define CSC_REF_RATIO_HI     5

// filter / feedback-high fields
`define CSC_FILT_RES_HI      7
`define CSC_FILT_RES_LO      4
`define CSC_FILT_ONLY        3
`define CSC_FB_HIGH_HI       2

// third loop pump fields
`define CSC_PUMP_OUT3_SRC    7
`define CSC_PUMP_W_HI        6
`define CSC_PUMP_W_LO        3
`define CSC_PUMP_DIV24       2
`define CSC_PUMP_DIV3        1
`define CSC_PUMP_BIAS        0
`define CSC_PUMP_DIV24_VAL   5'h18
`define CSC_PUMP_DIV3_VAL    5'h03

// first loop control fields
`define CSC_L1_DOUBLER       7
`define CSC_L1_BIAS          6
`define CSC_L1_CH2_EN        5
`define CSC_L1_POLE          4
`define CSC_L1_OUT5_HI       3

// effective divide ratios when bypassed
`define CSC_RATIO_BYP1       7'h01
`define CSC_RATIO_BYP2       7'h02

// bus target address base, 7-bit form of D0
`define CSC_BUS_ADDR_BASE    7'h68

`endif

/* hw/csc_pkg.sv */
// types shared by the clock synthesizer register bank
package csc_pkg;

  // serial target sequencer states, one-hot
  typedef enum logic [8:0] {
    CSC_IDLE    = 9'h001,
    CSC_DEV     = 9'h002,
    CSC_ACK_DEV = 9'h004,
    CSC_REG     = 9'h008,
    CSC_ACK_REG = 9'h010,
    CSC_WR      = 9'h020,
    CSC_ACK_WR  = 9'h040,
    CSC_RD      = 9'h080,
    CSC_RD_ACK  = 9'h100
  } csc_state_e;

  // decoded configuration presented to the synthesizer core
  typedef struct packed {
    logic        otp_programmed;
    logic [1:0]  bus_addr_select;
    logic        first_loop_spread_enable;
    logic        divider_one_source;
    logic        third_loop_ref_source;
    logic        otp_write_lock;
    logic [7:0]  config_variant_code;
    logic [7:0]  crystal_load_trim;
    logic        third_loop_ref_bypass_one;
    logic        third_loop_ref_bypass_two;
    logic [5:0]  third_loop_ref_ratio;
    logic [6:0]  third_loop_ref_effective;
    logic [10:0] third_loop_feedback_ratio;
    logic [3:0]  third_loop_filter_res;
    logic        third_loop_filter_res_only;
    logic        out3_divider_source;
    logic [3:0]  third_loop_pump_weight;
    logic        third_loop_pump_div24;
    logic        third_loop_pump_div3;
    logic        third_loop_bias_select;
    logic [4:0]  third_loop_pump_numerator;
    logic [4:0]  third_loop_pump_divisor;
    logic        first_loop_ref_doubler;
    logic        first_loop_bias_select;
    logic        first_loop_channel_two_enable;
    logic        first_loop_extra_pole_enable;
    logic [3:0]  out5_divider_code;
    logic        first_loop_ref_bypass_one;
    logic        first_loop_ref_bypass_two;
    logic [5:0]  first_loop_ref_ratio;
    logic [6:0]  first_loop_ref_effective;
    logic [10:0] first_loop_feedback_ratio;
    logic [4:0]  first_loop_filter_bits;
  } csc_cfg_s;

endpackage : csc_pkg

/* hw/csc_regs.sv */
// clock synthesizer configuration bank behind a two-wire serial target
//
// Functional notes
// - address field picks target D0, D2, D4, D6
// - general bit 4 enables first loop spread
// - general bit 3 picks divider one source
// - crystal load trim byte fully writable
// - third loop reference ratio, default 25
// - third loop reference bypass by one, two
// - third loop feedback eleven bits, default 480
// - third loop filter resistors, six-k only mode
// - out3 divider source second or third loop
// - pump current numerator and divisor sum
// - third loop bias doubles when set
// - first loop reference doubler, off at reset
// - first loop bias current select
// - first loop channel two, on at reset
// - first loop extra pole, off at reset
// - out5 divider code, reset 0011
// - first loop reference ratio, default 25
// - first loop reference bypass by one, two
// - first loop feedback low byte, reset 58
// - first loop feedback high bits, default 600
// - block write buffered, committed on stop
`timescale 1ns/1ns
`include "csc_consts.svh"

module csc_regs (
  input  wire logic              CORE_CLK,
  input  wire logic              RESETN,
  input  wire logic              SCL_IN,
  input  wire logic              SDA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE,
  output csc_pkg::csc_cfg_s      CFG
);
  import csc_pkg::*;

  // power-on values and writable masks per entry
  localparam logic [7:0] RESET_VAL [0:`CSC_NUM_REGS-1] = '{
    `CSC_RST_GENERAL, `CSC_RST_VARIANT, `CSC_RST_XTAL_TRIM, `CSC_RST_L3_REF,
    `CSC_RST_L3_FB_LOW, `CSC_RST_L3_FILT_FB, `CSC_RST_L3_PUMP, `CSC_RST_L1_CTRL,
    `CSC_RST_L1_REF, `CSC_RST_L1_FB_LOW, `CSC_RST_L1_FILT_FB};
  localparam logic [7:0] WMASK [0:`CSC_NUM_REGS-1] = '{
    `CSC_WMASK_GENERAL, `CSC_WMASK_FULL, `CSC_WMASK_FULL, `CSC_WMASK_FULL,
    `CSC_WMASK_FULL, `CSC_WMASK_FULL, `CSC_WMASK_FULL, `CSC_WMASK_FULL,
    `CSC_WMASK_FULL, `CSC_WMASK_FULL, `CSC_WMASK_FULL};

  // pin synchronisers; stage one is read only by stage two
  logic [2:0]           scl_sync_q;   // two sync stages plus history
  logic [2:0]           sda_sync_q;   // two sync stages plus history
  logic                 scl_rise;     // clock rose
  logic                 scl_fall;     // clock fell
  logic                 start_det;    // start or repeated start
  logic                 stop_det;     // stop condition

  // sequencer state
  csc_state_e           state_q, state_d;
  logic [3:0]           cnt_q, cnt_d;       // bits moved in this byte
  logic [7:0]           sr_q, sr_d;         // receive shifter
  logic [7:0]           tx_q, tx_d;         // transmit shifter
  logic [7:0]           ptr_q, ptr_d;       // register pointer
  logic                 rw_q, rw_d;         // read requested
  logic                 nack_q, nack_d;     // host refused more data
  logic                 oe_q, oe_d;         // pulling data line low
  logic [7:0]           shadow_q [0:`CSC_NUM_REGS-1];  // staged write bytes
  logic [7:0]           shadow_d [0:`CSC_NUM_REGS-1];
  logic [`CSC_NUM_REGS-1:0] pend_q, pend_d; // staged entries awaiting stop

  // register file
  logic [7:0]           regs_q [0:`CSC_NUM_REGS-1];
  logic [7:0]           regs_d [0:`CSC_NUM_REGS-1];

  // decoded outputs
  csc_cfg_s             cfg_d, cfg_q;
  logic [6:0]           own_addr;           // our 7-bit target address

  // read mux; unmapped offsets answer zero
  function automatic logic [7:0] rd_byte(input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < `CSC_NUM_REGS; i++)
    begin
      if (ofs == 8'(i))
      begin
        v = regs_q[i];
      end
    end
    return v;
  endfunction : rd_byte

  // two flops ahead of any logic; third stage only for edges
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], SCL_IN};
      sda_sync_q <= {sda_sync_q[1:0], SDA_IN};
    end
  end

  // edge and bus condition detect on synchronised stages only
  assign scl_rise  = scl_sync_q[1] & ~scl_sync_q[2];
  assign scl_fall  = ~scl_sync_q[1] & scl_sync_q[2];
  assign start_det = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
  assign stop_det  = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];

  // target address follows the select field live
  assign own_addr = `CSC_BUS_ADDR_BASE |
                    {5'h00, regs_q[0][`CSC_GEN_ADDR_HI:`CSC_GEN_ADDR_LO]};

  // sequencer next state
  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    sr_d     = sr_q;
    tx_d     = tx_q;
    ptr_d    = ptr_q;
    rw_d     = rw_q;
    nack_d   = nack_q;
    oe_d     = oe_q;
    shadow_d = shadow_q;
    pend_d   = pend_q;
    if (stop_det)
    begin
      // staged bytes move into the file this cycle
      pend_d  = '0;
      state_d = CSC_IDLE;
      oe_d    = 1'b0;
    end
    else if (start_det)
    begin
      // repeated start keeps staged bytes until the stop
      state_d = CSC_DEV;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end
    else
    begin
      case (state_q)
        CSC_IDLE:
        begin
          oe_d = 1'b0;
        end
        CSC_DEV:
        begin
          // compare after the eighth bit, ack on the falling edge
          if (scl_rise)
          begin
            sr_d  = {sr_q[6:0], sda_sync_q[1]};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == 4'h8)
          begin
            if (sr_q[7:1] == own_addr)
            begin
              rw_d    = sr_q[0];
              oe_d    = 1'b1;
              state_d = CSC_ACK_DEV;
            end
            else
            begin
              state_d = CSC_IDLE;
            end
          end
        end
        CSC_ACK_DEV:
        begin
          if (scl_fall)
          begin
            cnt_d = 4'h0;
            if (rw_q)
            begin
              // current read from the pointer
              tx_d    = rd_byte(ptr_q);
              oe_d    = ~tx_d[7];
              state_d = CSC_RD;
            end
            else
            begin
              oe_d    = 1'b0;
              state_d = CSC_REG;
            end
          end
        end
        CSC_REG:
        begin
          if (scl_rise)
          begin
            sr_d  = {sr_q[6:0], sda_sync_q[1]};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == 4'h8)
          begin
            ptr_d   = sr_q;
            oe_d    = 1'b1;
            state_d = CSC_ACK_REG;
          end
        end
        CSC_ACK_REG, CSC_ACK_WR:
        begin
          if (scl_fall)
          begin
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
            state_d = CSC_WR;
          end
        end
        CSC_WR:
        begin
          if (scl_rise)
          begin
            sr_d  = {sr_q[6:0], sda_sync_q[1]};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == 4'h8)
          begin
            // stage only; the file is untouched until the stop
            for (int i = 0; i < `CSC_NUM_REGS; i++)
            begin
              if (ptr_q == 8'(i))
              begin
                shadow_d[i] = sr_q;
                pend_d[i]   = 1'b1;
              end
            end
            ptr_d   = ptr_q + 8'h01;
            oe_d    = 1'b1;
            state_d = CSC_ACK_WR;
          end
        end
        CSC_RD:
        begin
          if (scl_rise)
          begin
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt_q == 4'h8)
            begin
              // let the host acknowledge
              oe_d    = 1'b0;
              ptr_d   = ptr_q + 8'h01;
              state_d = CSC_RD_ACK;
            end
            else
            begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = ~tx_d[7];
            end
          end
        end
        CSC_RD_ACK:
        begin
          if (scl_rise)
          begin
            nack_d = sda_sync_q[1];
          end
          else if (scl_fall)
          begin
            cnt_d = 4'h0;
            if (nack_q)
            begin
              // host is done; wait for stop or start
              state_d = CSC_IDLE;
            end
            else
            begin
              tx_d    = rd_byte(ptr_q);
              oe_d    = ~tx_d[7];
              state_d = CSC_RD;
            end
          end
        end
        default:
        begin
          state_d = CSC_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_q <= CSC_IDLE;
      cnt_q   <= 4'h0;
      sr_q    <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
      oe_q    <= 1'b0;
      pend_q  <= '0;
      for (int i = 0; i < `CSC_NUM_REGS; i++)
      begin
        shadow_q[i] <= 8'h00;
      end
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      sr_q     <= sr_d;
      tx_q     <= tx_d;
      ptr_q    <= ptr_d;
      rw_q     <= rw_d;
      nack_q   <= nack_d;
      oe_q     <= oe_d;
      pend_q   <= pend_d;
      shadow_q <= shadow_d;
    end
  end

  // one register per entry, staged entries committed together on the stop
  for (genvar g = 0; g < `CSC_NUM_REGS; g++)
  begin : g_reg
    // reserved bits are masked so they stay zero
    always_comb
    begin
      regs_d[g] = regs_q[g];
      if (stop_det && pend_q[g])
      begin
        regs_d[g] = shadow_q[g] & WMASK[g];
      end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
      if (!RESETN)
      begin
        regs_q[g] <= RESET_VAL[g];
      end
      else
      begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  // field decode toward the analog core
  always_comb
  begin
    cfg_d = '0;
    // general control
    cfg_d.otp_programmed            = regs_q[0][`CSC_GEN_OTP_DONE];
    cfg_d.bus_addr_select           = regs_q[0][`CSC_GEN_ADDR_HI:`CSC_GEN_ADDR_LO];
    cfg_d.first_loop_spread_enable  = regs_q[0][`CSC_GEN_SPREAD];
    cfg_d.divider_one_source        = regs_q[0][`CSC_GEN_DIV1_SRC];
    cfg_d.third_loop_ref_source     = regs_q[0][`CSC_GEN_L3_SRC];
    cfg_d.otp_write_lock            = regs_q[0][`CSC_GEN_OTP_LOCK];
    cfg_d.config_variant_code       = regs_q[1];
    cfg_d.crystal_load_trim         = regs_q[2];
    // third loop reference; bypass by one wins if both are set
    cfg_d.third_loop_ref_bypass_one = regs_q[3][`CSC_REF_BYP1];
    cfg_d.third_loop_ref_bypass_two = regs_q[3][`CSC_REF_BYP2];
    cfg_d.third_loop_ref_ratio      = regs_q[3][`CSC_REF_RATIO_HI:0];
    if (regs_q[3][`CSC_REF_BYP1])
      cfg_d.third_loop_ref_effective = `CSC_RATIO_BYP1;
    else if (regs_q[3][`CSC_REF_BYP2])
      cfg_d.third_loop_ref_effective = `CSC_RATIO_BYP2;
    else
      cfg_d.third_loop_ref_effective = {1'b0, regs_q[3][`CSC_REF_RATIO_HI:0]};
    cfg_d.third_loop_feedback_ratio = {regs_q[5][`CSC_FB_HIGH_HI:0], regs_q[4]};
    // six-k only mode drops the series resistors
    cfg_d.third_loop_filter_res_only = regs_q[5][`CSC_FILT_ONLY];
    cfg_d.third_loop_filter_res      = regs_q[5][`CSC_FILT_ONLY] ? 4'h0 :
                                       regs_q[5][`CSC_FILT_RES_HI:`CSC_FILT_RES_LO];
    // pump and out3 source
    cfg_d.out3_divider_source       = regs_q[6][`CSC_PUMP_OUT3_SRC];
    cfg_d.third_loop_pump_weight    = regs_q[6][`CSC_PUMP_W_HI:`CSC_PUMP_W_LO];
    cfg_d.third_loop_pump_div24     = regs_q[6][`CSC_PUMP_DIV24];
    cfg_d.third_loop_pump_div3      = regs_q[6][`CSC_PUMP_DIV3];
    cfg_d.third_loop_bias_select    = regs_q[6][`CSC_PUMP_BIAS];
    // weight bits are already binary weighted, so bias doubles by shift
    cfg_d.third_loop_pump_numerator = regs_q[6][`CSC_PUMP_BIAS] ?
                                      {regs_q[6][`CSC_PUMP_W_HI:`CSC_PUMP_W_LO], 1'b0} :
                                      {1'b0, regs_q[6][`CSC_PUMP_W_HI:`CSC_PUMP_W_LO]};
    cfg_d.third_loop_pump_divisor   = (regs_q[6][`CSC_PUMP_DIV24] ? `CSC_PUMP_DIV24_VAL : 5'h00) +
                                      (regs_q[6][`CSC_PUMP_DIV3] ? `CSC_PUMP_DIV3_VAL : 5'h00);
    // first loop control and out5
    cfg_d.first_loop_ref_doubler        = regs_q[7][`CSC_L1_DOUBLER];
    cfg_d.first_loop_bias_select        = regs_q[7][`CSC_L1_BIAS];
    cfg_d.first_loop_channel_two_enable = regs_q[7][`CSC_L1_CH2_EN];
    cfg_d.first_loop_extra_pole_enable  = regs_q[7][`CSC_L1_POLE];
    cfg_d.out5_divider_code             = regs_q[7][`CSC_L1_OUT5_HI:0];
    // first loop reference
    cfg_d.first_loop_ref_bypass_one = regs_q[8][`CSC_REF_BYP1];
    cfg_d.first_loop_ref_bypass_two = regs_q[8][`CSC_REF_BYP2];
    cfg_d.first_loop_ref_ratio      = regs_q[8][`CSC_REF_RATIO_HI:0];
    if (regs_q[8][`CSC_REF_BYP1])
      cfg_d.first_loop_ref_effective = `CSC_RATIO_BYP1;
    else if (regs_q[8][`CSC_REF_BYP2])
      cfg_d.first_loop_ref_effective = `CSC_RATIO_BYP2;
    else
      cfg_d.first_loop_ref_effective = {1'b0, regs_q[8][`CSC_REF_RATIO_HI:0]};
    cfg_d.first_loop_feedback_ratio = {regs_q[10][`CSC_FB_HIGH_HI:0], regs_q[9]};
    cfg_d.first_loop_filter_bits    = regs_q[10][`CSC_FILT_RES_HI:`CSC_FILT_ONLY];
  end

  // outputs straight from flops; data line is open drain so it only pulls low
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cfg_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end

  assign CFG     = cfg_q;
  assign SDA_OE  = oe_q;
  assign SDA_OUT = 1'b0;

endmodule : csc_regs

/* testbench/csc_checker.sv */
// port-level assertions for the clock synth register bank
`timescale 1ns/1ns
module csc_checker (
  input wire logic              CORE_CLK,
  input wire logic              RESETN,
  input wire logic              SCL_IN,
  input wire logic              SDA_IN,
  input wire logic              SDA_OUT,
  input wire logic              SDA_OE,
  input wire csc_pkg::csc_cfg_s CFG
);
  import csc_pkg::*;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  // release of reset, then power-on decode shows within a few edges
  sequence s_rel;
    $rose(RESETN);
  endsequence
  sequence s_dflt;
    CFG.third_loop_ref_ratio == 6'h19 && CFG.first_loop_channel_two_enable;
  endsequence
  property p_dflt;
    s_rel |-> ##[1:3] s_dflt;
  endproperty
  a_dflt: assert property (p_dflt) else $error("power-on decode wrong");
  // open drain: the pin level driven is only ever low
  property p_od;
    SDA_OUT == 1'h0;
  endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  // device moves data only while the serial clock is low
  property p_oe_scl;
    $changed(SDA_OE) |-> !SCL_IN;
  endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("data moved with clock high");
  // config only changes at a stop, clock high and settled
  property p_cfg_stop;
    $changed(CFG) |-> SCL_IN && $past(SCL_IN, 4);
  endproperty
  a_cfg_stop: assert property (p_cfg_stop) else $error("config changed outside stop");
  property p_l3_eff;
    CFG.third_loop_ref_effective == (CFG.third_loop_ref_bypass_one ? 7'h01 :
      CFG.third_loop_ref_bypass_two ? 7'h02 : {1'h0, CFG.third_loop_ref_ratio});
  endproperty
  a_l3_eff: assert property (p_l3_eff) else $error("loop3 ref ratio wrong");
  property p_l1_eff;
    CFG.first_loop_ref_effective == (CFG.first_loop_ref_bypass_one ? 7'h01 :
      CFG.first_loop_ref_bypass_two ? 7'h02 : {1'h0, CFG.first_loop_ref_ratio});
  endproperty
  a_l1_eff: assert property (p_l1_eff) else $error("loop1 ref ratio wrong");
  property p_num;
    CFG.third_loop_pump_numerator == ({1'h0, CFG.third_loop_pump_weight} << CFG.third_loop_bias_select);
  endproperty
  a_num: assert property (p_num) else $error("pump numerator wrong");
  property p_div;
    CFG.third_loop_pump_divisor == (CFG.third_loop_pump_div24 ? 5'h18 : 5'h00)
      + (CFG.third_loop_pump_div3 ? 5'h03 : 5'h00);
  endproperty
  a_div: assert property (p_div) else $error("pump divisor wrong");
  property p_res_only;
    CFG.third_loop_filter_res_only |-> CFG.third_loop_filter_res == 4'h0;
  endproperty
  a_res_only: assert property (p_res_only) else $error("filter not bypassed");
endmodule : csc_checker

bind csc_regs csc_checker csc_checker_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CFG(CFG));

/* testbench/csc_host.sv */
// two-wire bus host model facing the register bank
`timescale 1ns/1ns
module csc_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  localparam int H = 9; // cycles per clock phase, above the device minimum
  int slow = 0;         // extra high-phase cycles for a sluggish host
  // lines idle high, clock stands still between frames
  initial
  begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  // set data while clock low, then raise the clock
  task automatic phase(input logic b);
    wait_n(3);
    sda_drv = b;
    wait_n(H);
    scl = 1'h1;
    wait_n(H + slow);
  endtask : phase
  // start or repeated start: data falls with clock high
  task automatic start();
    phase(1'h1);
    sda_drv = 1'h0;
    wait_n(H);
    scl = 1'h0;
  endtask : start
  // stop ends every block write
  task automatic stop();
    phase(1'h0);
    sda_drv = 1'h1;
    wait_n(H);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    phase(b);
    r = sda;
    scl = 1'h0;
  endtask : bit_io
  // one byte msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask : xfer
endmodule : csc_host

/* testbench/csc_regs_tb.sv */
// self-checking bench for the clock synth register bank
`timescale 1ns/1ns
`include "csc_consts.svh"
module csc_regs_tb;
  import csc_pkg::*;
  logic       core_clk;     // 100 MHz
  logic       resetn;       // active-low reset
  logic       scl;          // host serial clock
  logic       sda_host;     // host data drive, 1 releases
  wire        sda;          // resolved data wire with pull-up
  logic       sda_out;      // device data level
  logic       sda_oe;       // device pulls low
  csc_cfg_s   cfg;          // decoded configuration
  csc_cfg_s   held;         // config seen before a stop
  logic [7:0] mdl [0:10];   // expected register contents
  logic [7:0] wbuf [0:11];  // bytes to write
  logic [7:0] rbuf [0:10];  // bytes read back
  logic [1:0] code;         // bus address select
  logic       ok;           // device acknowledged
  int         error_cnt;
  int         cmp_count;
  int         seed;
  int         cycles;
  assign sda = sda_oe ? (sda_out & sda_host) : sda_host;
  csc_host csc_host_i (.clk(core_clk), .sda(sda), .scl(scl), .sda_drv(sda_host));
  csc_regs csc_regs_i (.CORE_CLK(core_clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CFG(cfg));
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  // hang guard, roughly a fifth above the expected run length
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // reference ratio after the bypass bits, /1 taking priority
  function automatic logic [6:0] eff(input logic [7:0] r);
    return r[7] ? 7'h01 : r[6] ? 7'h02 : {1'h0, r[5:0]};
  endfunction : eff
  function automatic logic [9:0] pump(input logic [7:0] r);
    logic [4:0] n;
    n = {1'h0, r[6:3]} << r[0];
    return {n, (r[2] ? 5'h18 : 5'h00) + (r[1] ? 5'h03 : 5'h00)};
  endfunction : pump
  task automatic open_dev(input logic [7:0] a, output logic ack);
    logic [7:0] q;
    logic       n;
    csc_host_i.start();
    csc_host_i.xfer(a, 1'h1, q, n);
    ack = !n;
  endtask : open_dev
  // block write without the stop, model follows the bytes
  task automatic wr_blk(input logic [7:0] dev, input int n);
    logic [7:0] q;
    logic       a;
    open_dev(dev, ok);
    check(ok, 1'h1);
    csc_host_i.xfer(8'h00, 1'h1, q, a);
    for (int i = 0; i < n; i++)
    begin
      csc_host_i.xfer(wbuf[i], 1'h1, q, a);
      check(a, 1'h0);
      if (i < 11)
        mdl[i] = (i == 0) ? (wbuf[i] & 8'hFD) : wbuf[i];
    end
  endtask : wr_blk
  // read all registers back and compare the decode
  task automatic chk_all(input logic [7:0] dev);
    logic [7:0] q;
    logic       a;
    open_dev(dev, ok);
    csc_host_i.xfer(8'h00, 1'h1, q, a);
    open_dev(dev | 8'h01, ok);
    check(ok, 1'h1);
    for (int i = 0; i < 11; i++)
    begin
      csc_host_i.xfer(8'hFF, i == 10, rbuf[i], a);
      check(rbuf[i], mdl[i]);
    end
    csc_host_i.stop();
    check(cfg.bus_addr_select, mdl[0][6:5]);
    check(cfg.first_loop_spread_enable, mdl[0][4]);
    check(cfg.divider_one_source, mdl[0][3]);
    check({cfg.otp_programmed, cfg.third_loop_ref_source, cfg.otp_write_lock}, {mdl[0][7], mdl[0][2], mdl[0][0]});
    check(cfg.config_variant_code, mdl[1]);
    check(cfg.crystal_load_trim, mdl[2]);
    check(cfg.third_loop_ref_ratio, mdl[3][5:0]);
    check(cfg.third_loop_ref_effective, eff(mdl[3]));
    check(cfg.third_loop_feedback_ratio, {mdl[5][2:0], mdl[4]});
    check({cfg.third_loop_filter_res, cfg.third_loop_filter_res_only},
      {mdl[5][3] ? 4'h0 : mdl[5][7:4], mdl[5][3]});
    check(cfg.out3_divider_source, mdl[6][7]);
    check({cfg.third_loop_pump_numerator, cfg.third_loop_pump_divisor}, pump(mdl[6]));
    check(cfg.third_loop_bias_select, mdl[6][0]);
    check({cfg.first_loop_ref_doubler, cfg.first_loop_bias_select, cfg.first_loop_channel_two_enable,
      cfg.first_loop_extra_pole_enable, cfg.out5_divider_code}, mdl[7]);
    check(cfg.first_loop_ref_ratio, mdl[8][5:0]);
    check(cfg.first_loop_ref_effective, eff(mdl[8]));
    check(cfg.first_loop_feedback_ratio, {mdl[10][2:0], mdl[9]});
    check(cfg.first_loop_filter_bits, mdl[10][7:3]);
  endtask : chk_all
  initial
  begin
    seed = 35;
    error_cnt = 0;
    cmp_count = 0;
    cycles = 0;
    resetn = 1'h0;
    mdl = '{`CSC_RST_GENERAL, `CSC_RST_VARIANT, `CSC_RST_XTAL_TRIM, `CSC_RST_L3_REF,
      `CSC_RST_L3_FB_LOW, `CSC_RST_L3_FILT_FB, `CSC_RST_L3_PUMP, `CSC_RST_L1_CTRL,
      `CSC_RST_L1_REF, `CSC_RST_L1_FB_LOW, `CSC_RST_L1_FILT_FB};
    repeat (3) @(negedge core_clk);
    resetn = 1'h1;
    repeat (8) @(negedge core_clk);
    chk_all(8'hD0);
    // all ones, all zeros, then random; one byte past the bank is discarded
    for (int r = 0; r < 5; r++)
    begin
      for (int i = 0; i < 12; i++)
        wbuf[i] = (r == 0) ? 8'hFF : (r == 1) ? 8'h00 : 8'($random(seed));
      wbuf[0] = wbuf[0] & 8'h9F;
      csc_host_i.slow = r * 4;
      held = cfg;
      wr_blk(8'hD0, 12);
      check(cfg === held, 1'h1);
      csc_host_i.stop();
      chk_all(8'hD0);
    end
    // walk every address code; the code above the new one must stay silent
    for (int k = 1; k < 5; k++)
    begin
      wbuf[0] = {1'h0, code, 5'h00} | 8'h10;
      wbuf[0][6:5] = 2'(k);
      wr_blk(8'hD0 | {5'h00, code, 1'h0}, 1);
      csc_host_i.stop();
      code = 2'(k);
      open_dev(8'hD0 | {5'h00, code + 2'h1, 1'h0}, ok);
      csc_host_i.stop();
      check(ok, 1'h0);
      chk_all(8'hD0 | {5'h00, code, 1'h0});
    end
    give_verdict();
  end
  initial
    code = 2'h0;
endmodule : csc_regs_tb
